// ==== bench/swoc_assertions.sv ====
// port-level assertions for the switching output channel
`timescale 1ns/1ps
`default_nettype none
module swoc_checker #(
	parameter integer TICK_CYC = 10000
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// watched inputs
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_prio_valid,
	input wire logic i_prio_value,
	// watched outputs
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_relay,
	input wire logic o_state_tx,
	input wire logic o_state_val
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	// apb phases
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_access;
		i_psel && i_penable;
	endsequence
	//////////////////////////////////////////////////////////////////////////////
	apb_wait_a: assert property (s_setup ##1 s_access |-> !o_pready ##1 o_pready)
		else $error("apb answer not after one wait state");
	pready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	pready_access_a: assert property (o_pready |-> s_access)
		else $error("pready outside access phase");
	slverr_ready_a: assert property (o_pslverr |-> o_pready)
		else $error("pslverr without pready");
	reset_quiet_a: assert property ($fell(i_rst) |-> !o_relay && !o_state_tx && !o_pready)
		else $error("outputs not idle out of reset");
	state_value_a: assert property (o_state_tx |-> o_state_val == $past(o_relay))
		else $error("state value differs from relay");
	state_pulse_a: assert property (o_state_tx |=> !o_state_tx)
		else $error("state telegram longer than one cycle");
	prio_wins_a: assert property (i_prio_valid |=> o_relay == $past(i_prio_value))
		else $error("priority command not applied");
endmodule
bind swoc_channel swoc_checker #(.TICK_CYC(TICK_CYC)) u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_psel(i_psel), .i_penable(i_penable), .i_prio_valid(i_prio_valid), .i_prio_value(i_prio_value),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_relay(o_relay), .o_state_tx(o_state_tx),
	.o_state_val(o_state_val));
`default_nettype wire

// ==== bench/swoc_bus_model.sv ====
// bus telegram source standing in for the building bus
`timescale 1ns/1ps
`default_nettype none
module swoc_bus_model (
	// clock
	input  wire logic i_core_clk,
	// telegram strobes and shared payload
	output logic [6:0] o_valid,
	output logic [7:0] o_data
);
	initial begin
		o_valid = 7'h00;
		o_data  = 8'h5a;
	end
	// one-cycle telegram; payload scrambled once released
	task send(input int kind, input logic [7:0] val);
		@(posedge i_core_clk);
		o_valid[kind] <= 1'b1;
		o_data <= val;
		@(posedge i_core_clk);
		o_valid <= 7'h00;
		o_data <= ~val;
	endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the switching output channel
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk, rst, psel, penable, pwrite, nv, fail;
	logic [7:0]  paddr, lvl;
	logic [31:0] pwdata, prdata, bad[3];
	logic        pready, pslverr, relay, stx, sval, r;
	wire  [6:0]  tv;
	wire  [7:0]  td;
	logic        vtx;
	logic [7:0]  vval;
	logic [7:0]  vq[$];
	logic [33:0] apq[$], e;
	logic        txq[$];
	int          n_mismatch, comparisons, n;

	swoc_channel #(.TICK_CYC(10)) DUT (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_sw_valid(tv[0]), .i_sw_value(td[0]), .i_prio_valid(tv[1]),
		.i_prio_value(td[0]), .i_lock_valid(tv[2]), .i_lock_value(td[0]), .i_scene_valid(tv[3]),
		.i_scene_byte(td), .i_dim_valid(tv[4]), .i_dim_level(td), .i_valve_valid(tv[6]),
		.i_valve_value(td), .i_read_req(tv[5]), .i_nv_state(nv), .i_bus_fail(fail), .o_relay(relay),
		.o_state_tx(stx), .o_state_val(sval), .o_valve_tx(vtx), .o_valve_val(vval));
	swoc_bus_model BUS (.i_core_clk(clk), .o_valid(tv), .o_data(td));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	//////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task tmo;
		n_mismatch++;
		complete_run();
	endtask
	// apb transfer; reads carry the expected data in d
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
		@(posedge clk);
		apq.push_back({!w, er, d});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) tmo();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// telegram, then relay level a cycle later
	task tg(input int k, input logic [7:0] v, input logic x);
		BUS.send(k, v);
		@(posedge clk);
		chk("relay", relay, x);
	endtask
	// compare answers against the oldest note
	always @(posedge clk) begin
		if (pready === 1'b1) begin
			e = apq.pop_front();
			chk("pslverr", pslverr, e[32]);
			if (e[33]) chk("prdata", prdata, e[31:0]);
		end
		if (stx === 1'b1) begin
			if (txq.size() == 0) chk("state_tx", 1'b1, 1'b0);
			else chk("state_val", sval, txq.pop_front());
		end
		if (vtx === 1'b1) begin
			if (vq.size() == 0) chk("valve_tx", 1'b1, 1'b0);
			else chk("valve_val", vval, vq.pop_front());
		end
	end
	// main sequence
	initial begin
		{rst, nv} = 2'h3;
		{psel, penable, pwrite, fail} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		bad = '{32'h0000_0015, 32'h0000_0041, 32'h0000_0000};
		void'($urandom(80));
		txq.push_back(1'b1);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk("relay", relay, 1'b1);
		apb(1'b0, 8'h00, 32'h0000_032a, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0012, 1'b0);
		txq.delete();
		repeat (4) begin
			r = 1'($urandom_range(1, 0));
			tg(0, {7'h00, r}, r);
		end
		txq.push_back(r);
		tg(5, 8'h00, r);
		apb(1'b1, 8'h00, 32'h0000_0002, 1'b0);
		tg(5, 8'h00, r);
		apb(1'b1, 8'h00, 32'h0000_0022, 1'b0);
		txq.push_back(!r);
		tg(0, {7'h00, !r}, !r);
		tg(0, {7'h00, !r}, !r);
		apb(1'b1, 8'h00, 32'h0000_e412, 1'b0);
		tg(0, 8'h01, 1'b1);
		tg(2, 8'h01, 1'b0);
		tg(0, 8'h01, 1'b0);
		tg(1, 8'h01, 1'b1);
		tg(1, 8'h00, 1'b0);
		tg(2, 8'h00, 1'b1);
		apb(1'b1, 8'h00, 32'h0001_0c12, 1'b0);
		tg(2, 8'h00, 1'b1);
		tg(0, 8'h00, 1'b1);
		tg(2, 8'h01, 1'b0);
		apb(1'b1, 8'h40, 32'h0000_0115, 1'b0);
		apb(1'b1, 8'h44, 32'h0000_0316, 1'b0);
		foreach (bad[i]) apb(1'b1, 8'h48, bad[i], 1'b1);
		apb(1'b0, 8'h48, 32'h0000_0003, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_001a, 1'b0);
		tg(3, 8'h14, 1'b1);
		tg(0, 8'h00, 1'b0);
		tg(3, 8'h95, 1'b0);
		tg(0, 8'h01, 1'b1);
		tg(3, 8'h15, 1'b0);
		apb(1'b0, 8'h20, 32'h0000_0000, 1'b1);
		apb(1'b1, 8'h0c, 32'h0000_0000, 1'b1);
		apb(1'b1, 8'h08, 32'h0000_0002, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0011, 1'b0);
		lvl = 8'($urandom_range(255, 1));
		tg(4, lvl, 1'b1);
		tg(4, 8'h00, 1'b1);
		n = 0;
		while (relay !== 1'b0 && n < 60) begin
			@(posedge clk);
			n++;
		end
		chk("off_delay", n >= 18 && n <= 31, 1'b1);
		apb(1'b1, 8'h08, 32'h0000_0000, 1'b0);
		tg(4, lvl, 1'b1);
		tg(4, 8'h00, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0010, 1'b0);
		tg(0, 8'h01, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0052, 1'b0);
		fail <= 1'b1;
		repeat (5) @(posedge clk);
		chk("relay", relay, 1'b1);
		fail <= 1'b0;
		apb(1'b1, 8'h00, 32'h0000_0025, 1'b0);
		vq.push_back(8'h40);
		tg(6, 8'h40, 1'b1);
		apb(1'b1, 8'h04, 32'h0000_0001, 1'b0);
		txq.push_back(1'b1);
		apb(1'b1, 8'h00, 32'h0000_0032, 1'b0);
		n = 0;
		while (txq.size() != 0 && n < 12000) begin
			@(posedge clk);
			n++;
		end
		if (txq.size() != 0) tmo();
		complete_run();
	end
endmodule
`default_nettype wire

// ==== logic/swoc_channel.v ====
// switching output channel control with apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "swoc_consts.vh"

module swoc_channel #(
	parameter integer TICK_CYC = `SWOC_MS_CYC
) (
	// clock and reset
	input  wire        i_core_clk,
	input  wire        i_rst,
	// apb slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [7:0]  i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	// received telegrams
	input  wire        i_sw_valid,
	input  wire        i_sw_value,
	input  wire        i_prio_valid,
	input  wire        i_prio_value,
	input  wire        i_lock_valid,
	input  wire        i_lock_value,
	input  wire        i_scene_valid,
	input  wire [7:0]  i_scene_byte,
	input  wire        i_dim_valid,
	input  wire [7:0]  i_dim_level,
	input  wire        i_valve_valid,
	input  wire [7:0]  i_valve_value,
	input  wire        i_read_req,
	// retained relay position and bus power pin
	input  wire        i_nv_state,
	input  wire        i_bus_fail,
	// relay and state telegrams
	output reg         o_relay,
	output reg         o_state_tx,
	output reg         o_state_val,
	output reg         o_valve_tx,
	output reg  [7:0]  o_valve_val
);

	localparam [15:0] TICK_LAST = TICK_CYC[15:0] - 16'h0001;

	//////////////////////////////////////////////////////////////////////////
	// configuration and state
	reg [`SWOC_CTRL_W-1:0] ctrl;
	reg [15:0]             cycle_s;
	reg [15:0]             delay_ms;
	reg                    lock_act;
	reg                    held;
	reg                    last_cmd;
	reg                    init;
	reg                    fail_s1;
	reg                    fail_s2;
	reg                    fail_d;
	reg                    relay_d;
	reg                    off_pend;
	reg [15:0]             off_cnt;
	reg [15:0]             pre;
	reg [15:0]             ms_cnt;
	reg [15:0]             sec_cnt;
	reg [7:0]              valve;

	wire [2:0] mode     = ctrl[`SWOC_F_MODE];
	wire [1:0] report   = ctrl[`SWOC_F_REPORT];
	wire [2:0] fail_act = {1'b0, ctrl[`SWOC_F_FAIL]};
	wire [2:0] ret_act  = {1'b0, ctrl[`SWOC_F_RETURN]};
	wire [2:0] ent_act  = {1'b0, ctrl[`SWOC_F_ENTRY]};
	wire [2:0] exit_act = ctrl[`SWOC_F_EXIT];

	//////////////////////////////////////////////////////////////////////////
	// apb decode
	wire       apb_acc  = i_psel & i_penable & ~o_pready;
	wire       apb_wr   = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
	wire       is_scene = (i_paddr >= `SWOC_REG_SCENE0) && (i_paddr <= `SWOC_REG_SCENE_LAST) && (i_paddr[1:0] == 2'h0);
	wire [3:0] widx     = i_paddr[5:2];
	wire [6:0] wnum     = i_pwdata[`SWOC_F_SC_NUM];
	wire       num_bad  = (wnum == 7'h00) || (wnum > `SWOC_SC_MAX);

	//////////////////////////////////////////////////////////////////////////
	// time base: millisecond and second ticks
	wire ms_tick  = (pre == TICK_LAST);
	wire sec_tick = ms_tick && (ms_cnt == `SWOC_SEC_MS - 16'h0001);

	always @(posedge i_core_clk) begin
		if (i_rst) begin
			pre    <= 16'h0000;
			ms_cnt <= 16'h0000;
		end else begin
			pre <= ms_tick ? 16'h0000 : pre + 16'h0001;
			if (ms_tick)
				ms_cnt <= sec_tick ? 16'h0000 : ms_cnt + 16'h0001;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// bus power failure pin synchroniser and edge
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			fail_s1 <= 1'b0;
			fail_s2 <= 1'b0;
			fail_d  <= 1'b0;
		end else begin
			fail_s1 <= i_bus_fail;
			fail_s2 <= fail_s1;
			fail_d  <= fail_s2;
		end
	end
	wire fail_rise = fail_s2 & ~fail_d;

	//////////////////////////////////////////////////////////////////////////
	// scene slots: storage, match and duplicate check
	wire        scene_ok = ctrl[`SWOC_F_SCENE_EN] && (mode == `SWOC_MODE_UNIV) && i_scene_valid;
	wire        sc_learn = i_scene_byte[7];
	wire [6:0]  sc_want  = {1'b0, i_scene_byte[5:0]} + 7'h01;
	wire [15:0] hit;
	wire [15:0] dup;
	wire [111:0] sc_num_f;
	wire [31:0]  sc_act_f;
	wire [15:0]  sc_lrn_f;

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_sc
			localparam integer RST_I = gi + 1;
			localparam [6:0]   RST_NUM = RST_I[6:0];
			reg [6:0] num;
			reg [1:0] act;
			reg       lrn;
			wire      wsel = apb_wr && is_scene && (widx == gi);
			// one entry per slot, learn store wins over a software write
			always @(posedge i_core_clk) begin
				if (i_rst) begin
					num <= RST_NUM;
					act <= `SWOC_SC_NONE;
					lrn <= 1'b0;
				end else begin
					if (wsel) begin
						num <= wnum;
						act <= i_pwdata[`SWOC_F_SC_ACT];
						lrn <= i_pwdata[`SWOC_F_SC_LRN];
					end
					if (scene_ok && sc_learn && hit[gi] && act == `SWOC_SC_LEARN)
						lrn <= o_relay;
				end
			end
			assign hit[gi] = (num == sc_want);
			assign dup[gi] = (num == wnum) && (widx != gi);
			assign sc_num_f[gi*7 +: 7] = num;
			assign sc_act_f[gi*2 +: 2] = act;
			assign sc_lrn_f[gi]        = lrn;
		end
	endgenerate

	// lowest slot wins a match
	reg [3:0] sel;
	reg       sel_hit;
	integer   k;
	always @* begin
		sel     = 4'h0;
		sel_hit = 1'b0;
		for (k = 15; k >= 0; k = k - 1) begin
			if (hit[k]) begin
				sel     = k[3:0];
				sel_hit = 1'b1;
			end
		end
	end
	wire [1:0] sel_act = sc_act_f[sel*2 +: 2];
	wire       sc_cmd  = scene_ok && !sc_learn && sel_hit && (sel_act != `SWOC_SC_NONE);
	wire       sc_val  = (sel_act == `SWOC_SC_ON) ? 1'b1 :
	                     (sel_act == `SWOC_SC_OFF) ? 1'b0 : sc_lrn_f[sel];

	//////////////////////////////////////////////////////////////////////////
	// dimmer follower with switch-off delay
	wire dim_on   = (mode == `SWOC_MODE_DIM) && i_dim_valid && (i_dim_level != 8'h00);
	wire dim_zero = (mode == `SWOC_MODE_DIM) && i_dim_valid && (i_dim_level == 8'h00);
	wire dim_off  = (dim_zero && delay_ms == 16'h0000) ||
	                ((mode == `SWOC_MODE_DIM) && off_pend && ms_tick && off_cnt == 16'h0000);

	always @(posedge i_core_clk) begin
		if (i_rst) begin
			off_pend <= 1'b0;
			off_cnt  <= 16'h0000;
		end else if (dim_on || mode != `SWOC_MODE_DIM) begin
			off_pend <= 1'b0;
		end else if (dim_zero) begin
			off_pend <= (delay_ms != 16'h0000);
			off_cnt  <= delay_ms;                                        // full delay, first tick is partial
		end else if (off_pend && ms_tick) begin
			if (off_cnt == 16'h0000)
				off_pend <= 1'b0;
			else
				off_cnt <= off_cnt - 16'h0001;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// switching command merge
	wire sw_cmd  = (mode == `SWOC_MODE_UNIV) && i_sw_valid;
	wire cmd     = sw_cmd | sc_cmd | dim_on | dim_off;
	wire cmd_val = dim_on ? 1'b1 : dim_off ? 1'b0 : sc_cmd ? sc_val : i_sw_value;
	wire lock_rq = i_lock_value ^ ctrl[`SWOC_F_LOCK_POL];

	// next relay, lock and remembered states
	reg next_relay;
	reg next_lock;
	reg next_held;
	reg next_last;
	always @* begin
		next_relay = o_relay;
		next_lock  = lock_act;
		next_held  = held;
		next_last  = last_cmd;
		if (init) begin
			case (ret_act)
				`SWOC_ACT_ON:  next_relay = 1'b1;
				`SWOC_ACT_OFF: next_relay = 1'b0;
				default:       next_relay = i_nv_state;
			endcase
		end else begin
			if (cmd) begin
				next_last = cmd_val;
				if (!lock_act)
					next_relay = cmd_val;
			end
			if (i_lock_valid && ctrl[`SWOC_F_LOCK_EN] && mode != `SWOC_MODE_OFF) begin
				if (lock_rq && !lock_act) begin
					next_lock = 1'b1;
					next_held = o_relay;
					case (ent_act)
						`SWOC_ACT_ON:  next_relay = 1'b1;
						`SWOC_ACT_OFF: next_relay = 1'b0;
						default:       next_relay = next_relay;
					endcase
				end else if (!lock_rq && lock_act) begin
					next_lock = 1'b0;
					case (exit_act)
						`SWOC_ACT_ON:    next_relay = 1'b1;
						`SWOC_ACT_OFF:   next_relay = 1'b0;
						`SWOC_ACT_PREV:  next_relay = held;
						`SWOC_ACT_TRACK: next_relay = next_last;
						default:         next_relay = next_relay;
					endcase
				end
			end
			if (i_prio_valid && mode != `SWOC_MODE_OFF)
				next_relay = i_prio_value;
			if (fail_rise) begin
				case (fail_act)
					`SWOC_ACT_ON:  next_relay = 1'b1;
					`SWOC_ACT_OFF: next_relay = 1'b0;
					default:       next_relay = next_relay;
				endcase
			end
		end
	end

	always @(posedge i_core_clk) begin
		if (i_rst) begin
			init     <= 1'b1;
			o_relay  <= 1'b0;
			lock_act <= 1'b0;
			held     <= 1'b0;
			last_cmd <= 1'b0;
		end else begin
			init     <= 1'b0;
			o_relay  <= next_relay;
			lock_act <= next_lock;
			held     <= next_held;
			last_cmd <= next_last;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// state reporting
	wire changed = (o_relay != relay_d) && !init;
	wire cyc_due = (report == `SWOC_REP_CYCLIC) && sec_tick && (sec_cnt >= cycle_s - 16'h0001);
	wire tx_now  = (report != `SWOC_REP_NONE) && (i_read_req ||
	               (changed && report[1]) || cyc_due);

	always @(posedge i_core_clk) begin
		if (i_rst) begin
			relay_d     <= 1'b0;
			sec_cnt     <= 16'h0000;
			o_state_tx  <= 1'b0;
			o_state_val <= 1'b0;
			valve       <= 8'h00;
			o_valve_tx  <= 1'b0;
			o_valve_val <= 8'h00;
		end else begin
			relay_d     <= o_relay;
			o_state_tx  <= tx_now;
			o_state_val <= o_relay;
			if (cyc_due || report != `SWOC_REP_CYCLIC)
				sec_cnt <= 16'h0000;
			else if (sec_tick)
				sec_cnt <= sec_cnt + 16'h0001;
			if (i_valve_valid && mode == `SWOC_MODE_VALVE)
				valve <= i_valve_value;
			o_valve_tx  <= (mode == `SWOC_MODE_VALVE) && (report != `SWOC_REP_NONE) &&
			               (i_read_req || (i_valve_valid && report[1] && i_valve_value != valve) ||
			                cyc_due);
			o_valve_val <= (i_valve_valid && mode == `SWOC_MODE_VALVE) ? i_valve_value : valve;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// apb registers: one wait state, error flagged in the access cycle
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			ctrl      <= `SWOC_CTRL_RST;
			cycle_s   <= `SWOC_CYC_RST;
			delay_ms  <= `SWOC_DELAY_RST;
			o_prdata  <= 32'h0000_0000;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= apb_acc;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			if (apb_acc) begin
				if (is_scene) begin
					o_pslverr <= i_pwrite && (num_bad || (|dup));
					o_prdata  <= {19'h0_0000, sc_lrn_f[widx], 2'h0, sc_act_f[widx*2 +: 2], 1'b0, sc_num_f[widx*7 +: 7]};
				end else begin
					case (i_paddr)
						`SWOC_REG_CTRL:   o_prdata <= {15'h0000, ctrl};
						`SWOC_REG_CYCLE:  o_prdata <= {16'h0000, cycle_s};
						`SWOC_REG_DELAY:  o_prdata <= {16'h0000, delay_ms};
						`SWOC_REG_STATUS: begin
							o_prdata  <= {27'h000_0000, off_pend, last_cmd, held, lock_act, o_relay};
							o_pslverr <= i_pwrite;
						end
						default:          o_pslverr <= 1'b1;
					endcase
				end
			end
			if (apb_wr) begin
				case (i_paddr)
					`SWOC_REG_CTRL:  ctrl     <= i_pwdata[`SWOC_CTRL_W-1:0];
					`SWOC_REG_CYCLE: cycle_s  <= i_pwdata[15:0];
					`SWOC_REG_DELAY: delay_ms <= i_pwdata[15:0];
					default:         ctrl     <= ctrl;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ==== logic/swoc_consts.vh ====
// constants of the switching output channel control block
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - selected mode gates switch, scene and dimmer commands; off also ignores lock and priority
// - bus power failure applies configured action
// - every restart applies return action of the ctrl reset value (retained position)
// - reporting disabled means no state telegrams
// - read-only reporting answers read requests only
// - change reporting sends on state change
// - cyclic reporting also sends every period
// - one-bit state; valve byte only valve mode
// - active lock blocks received switching commands
// - priority command switches output despite lock
// - lock entry applies none, on or off
// - lock exit none/on/off/restore entry state
// - tracking exit applies last received command
// - dimmer level zero opens, nonzero closes relay
// - configurable delay before dimmer opens relay
// - universal mode follows one-bit switch command
// - sixteen scene slots with configurable reaction
// - scene numbers one to sixty-four, unique
// - learn command stores output for learnable slot
//////////////////////////////////////////////////////////////////////////////
`ifndef SWOC_CONSTS_VH
`define SWOC_CONSTS_VH

// register byte offsets
`define SWOC_REG_CTRL       8'h00
`define SWOC_REG_CYCLE      8'h04
`define SWOC_REG_DELAY      8'h08
`define SWOC_REG_STATUS     8'h0c
`define SWOC_REG_SCENE0     8'h40
`define SWOC_REG_SCENE_LAST 8'h7c

// control register fields
`define SWOC_F_MODE     2:0
`define SWOC_F_SCENE_EN 3
`define SWOC_F_REPORT   5:4
`define SWOC_F_FAIL     7:6
`define SWOC_F_RETURN   9:8
`define SWOC_F_LOCK_EN  10
`define SWOC_F_LOCK_POL 11
`define SWOC_F_ENTRY    13:12
`define SWOC_F_EXIT     16:14
`define SWOC_CTRL_W     17
`define SWOC_CTRL_RST   17'h0_032a

// operating modes
`define SWOC_MODE_OFF   3'h0
`define SWOC_MODE_DIM   3'h1
`define SWOC_MODE_UNIV  3'h2
`define SWOC_MODE_DELAY 3'h3
`define SWOC_MODE_STAIR 3'h4
`define SWOC_MODE_VALVE 3'h5

// reporting modes
`define SWOC_REP_NONE   2'h0
`define SWOC_REP_READ   2'h1
`define SWOC_REP_CHANGE 2'h2
`define SWOC_REP_CYCLIC 2'h3

// output actions (failure, return, lock entry, lock exit)
`define SWOC_ACT_NONE  3'h0
`define SWOC_ACT_ON    3'h1
`define SWOC_ACT_OFF   3'h2
`define SWOC_ACT_PREV  3'h3
`define SWOC_ACT_TRACK 3'h4

// scene slot fields and reactions
`define SWOC_F_SC_NUM 6:0
`define SWOC_F_SC_ACT 9:8
`define SWOC_F_SC_LRN 12
`define SWOC_SC_NONE  2'h0
`define SWOC_SC_ON    2'h1
`define SWOC_SC_OFF   2'h2
`define SWOC_SC_LEARN 2'h3
`define SWOC_SC_MAX   7'h40

// timing
`define SWOC_CLK_PERIOD_NS 100
`define SWOC_MS_NS         1000000
`define SWOC_MS_CYC        (`SWOC_MS_NS / `SWOC_CLK_PERIOD_NS)
`define SWOC_SEC_MS        16'h03e8
`define SWOC_CYC_HOURS     6
`define SWOC_CYC_RST       16'h5460
`define SWOC_DELAY_RST     16'h0000

`endif

// ==== logic/swoc_dummy_unused.v ====
// holds no logic; the whole channel sits in swoc_channel
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
